// ==== stfe_pkg.sv ====
/*
  Shared constants for the four-lane serial transmit front end and the
  system-side logic that feeds it. Assumes one 50 MHz clock for both ends.
// Notes on behaviour
// - encode byte to ten bits, shift out serially
// - precoded mode: byte lines carry code bits 7..0
// - precoded mode: special flag is code bit 8
// - precoded mode: idle request is code bit 9
// - special flag marks control code, decided with idle
// - idle request low sends idle character
// - lane inputs timed to lane clock, rate-dependent
// - common clock select uses lane A clock
// - lane off disables lane, outputs undriven
// - alt select picks redundant pair, else primary
// - broadcast drives both pairs regardless of select
// - broadcast never overrides lane off
// - boost enable adds high-frequency gain
// - four independent lanes A to D
// - special flag low means ordinary data
// - precoded enable bypasses the encoder
// - inputs sampled on both lane clock edges
*/
package stfe_pkg;
  localparam int          LANES      = 4;
  localparam int          CHAR_BITS  = 10;
  localparam int          HALF_DIV   = 2;             // bit stretch at half rate
  localparam logic [7:0]  IDLE_BYTE  = 8'hBC;         // K28.5
  localparam logic [7:0]  IDLE_ALT   = 8'h3C;         // K28.1
  localparam logic [9:0]  IDLE_CODE  = 10'h0FA;       // K28.5, negative disparity
  localparam logic [5:0]  K28_SIX    = 6'h0F;
  localparam logic [4:0]  K28_X      = 5'h1C;
  localparam logic        RD_RESET   = 1'b0;          // negative disparity
  // register map of the system-side end
  localparam int          AXI_AW     = 4;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_TXDATA = 4'h4;
  localparam logic [3:0]  OFS_STATUS = 4'h8;
  localparam logic [3:0]  OFS_SENT   = 4'hC;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam int          CTRL_PRE   = 0;
  localparam int          CTRL_COM   = 1;
  localparam int          CTRL_BOTH  = 2;
  localparam int          CTRL_BOOST = 3;
  localparam int          CTRL_HALF  = 4;
  localparam int          CTRL_DDR   = 5;
  localparam int          CTRL_OFF   = 8;             // 4 bits, one per lane
  localparam int          CTRL_ALT   = 12;            // 4 bits, one per lane
  localparam int          TXD_K      = 8;
  localparam int          TXD_IDLE   = 9;
  localparam int          TXD_LANE   = 10;            // 2 bits
  localparam int          TXD_W      = 12;
  localparam int          FIFO_DEPTH = 32;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : stfe_pkg

// ==== stfe_par_if.sv ====
/*
  Parallel transmit interface between system logic and the transmit
  front end. Levels only; both ends sample on the common clock.
*/
`timescale 1ns/1ps
interface stfe_par_if;
  logic [stfe_pkg::LANES-1:0][7:0] tx_byte_in;
  logic [stfe_pkg::LANES-1:0]      tx_special_flag;
  logic [stfe_pkg::LANES-1:0]      tx_idle_req_n;
  logic [stfe_pkg::LANES-1:0]      tx_lane_if_clk;
  logic [stfe_pkg::LANES-1:0]      lane_off;
  logic [stfe_pkg::LANES-1:0]      lane_alt_pair_sel;
  logic                            tx_common_clk_sel;
  logic                            tx_both_pairs_on;
  logic                            tx_hf_boost_on;
  logic                            precoded_mode_on;
  logic                            half_rate_on;
  logic                            double_rate_on;

  modport dev (
    input tx_byte_in, tx_special_flag, tx_idle_req_n, tx_lane_if_clk, lane_off,
    input lane_alt_pair_sel, tx_common_clk_sel, tx_both_pairs_on, tx_hf_boost_on,
    input precoded_mode_on, half_rate_on, double_rate_on
  );
  modport host (
    output tx_byte_in, tx_special_flag, tx_idle_req_n, tx_lane_if_clk, lane_off,
    output lane_alt_pair_sel, tx_common_clk_sel, tx_both_pairs_on, tx_hf_boost_on,
    output precoded_mode_on, half_rate_on, double_rate_on
  );
endinterface : stfe_par_if

// ==== stfe_host.sv ====
/*
  System-side end: AXI4-Lite register slave, a character FIFO and the
  lane clock generator that presents one character per lane clock edge.
  Assumes the transmit end samples the interface on the same clock.
*/
`timescale 1ns/1ps
module stfe_fifo #(
  parameter int W = 12,
  parameter int D = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  // honest full and empty straight from the count
  assign in_ready  = cnt_r != (AW+1)'(D);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem[rp_r];
  assign level     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(pop));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset, contents only read when counted
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end
endmodule : stfe_fifo

module stfe_host (
  input  wire logic                    CLOCK,
  input  wire logic                    RESET,
  stfe_par_if.host                     par,
  input  wire logic [stfe_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output logic                         S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output logic                         S_AXI_WREADY,
  output logic [1:0]                   S_AXI_BRESP,
  output logic                         S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  input  wire logic [stfe_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output logic                         S_AXI_ARREADY,
  output logic [31:0]                  S_AXI_RDATA,
  output logic [1:0]                   S_AXI_RRESP,
  output logic                         S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY
);
  import stfe_pkg::*;

  logic [AXI_AW-1:0]   awaddr_r, awaddr_nxt;
  logic [31:0]         wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]          wstrb_r, wstrb_nxt;
  logic                aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic                awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, arrdy_r, arrdy_nxt;
  logic                bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [15:0]         ctrl_r, ctrl_nxt, sent_r, sent_nxt;
  logic [4:0]          cnt_r, cnt_nxt;
  logic                lclk_r, lclk_nxt, slot;
  logic [LANES-1:0][7:0] byte_r, byte_nxt;
  logic [LANES-1:0]    k_r, k_nxt, idle_r, idle_nxt;
  logic                do_wr, f_in_ready, f_out_valid;
  logic [TXD_W-1:0]    f_out;
  logic [$clog2(FIFO_DEPTH):0] f_level;

  assign do_wr = aw_got_r && w_got_r && !bvalid_r
                 && (awaddr_r != OFS_TXDATA || f_in_ready);
  assign slot  = cnt_r == 5'((ctrl_r[CTRL_HALF] ? HALF_DIV : 1) * CHAR_BITS - 1);

  // characters wait here; full fifo stalls the register write
  stfe_fifo #(.W(TXD_W), .D(FIFO_DEPTH)) stfe_fifo_inst (
    .clk       (CLOCK),
    .rst       (RESET),
    .in_valid  (do_wr && awaddr_r == OFS_TXDATA),
    .in_ready  (f_in_ready),
    .in_data   (wdata_r[TXD_W-1:0]),
    .out_valid (f_out_valid),
    .out_ready (slot),
    .out_data  (f_out),
    .level     (f_level)
  );

  // bus slave: address and data taken in either order
  always_comb
  begin
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    bvalid_nxt = bvalid_r && !S_AXI_BREADY;
    bresp_nxt  = bresp_r;
    ctrl_nxt   = ctrl_r;
    if (S_AXI_AWVALID && awrdy_r)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wrdy_r)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
    end
    if (do_wr)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      if (awaddr_r == OFS_CTRL)
      begin
        if (wstrb_r[0])
          ctrl_nxt[7:0] = wdata_r[7:0];
        if (wstrb_r[1])
          ctrl_nxt[15:8] = wdata_r[15:8];
      end
      else if (awaddr_r != OFS_TXDATA)
        bresp_nxt = RESP_SLVERR;
    end
    awrdy_nxt  = !aw_got_nxt && !bvalid_nxt;
    wrdy_nxt   = !w_got_nxt && !bvalid_nxt;
    rvalid_nxt = rvalid_r && !S_AXI_RREADY;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (S_AXI_ARVALID && arrdy_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (S_AXI_ARADDR)
        OFS_CTRL:   rdata_nxt = {16'h0000, ctrl_r};
        OFS_STATUS: rdata_nxt = 32'({!f_in_ready, !f_out_valid, 2'b00, f_level});
        OFS_SENT:   rdata_nxt = {16'h0000, sent_r};
        OFS_TXDATA: rdata_nxt = 32'h0000_0000;
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    arrdy_nxt = !rvalid_nxt;
  end

  // lane clock: one edge per character slot, new values at each edge
  always_comb
  begin
    cnt_nxt  = slot ? 5'h00 : 5'(cnt_r + 1'b1);
    lclk_nxt = slot ? !lclk_r : lclk_r;
    sent_nxt = (slot && f_out_valid) ? 16'(sent_r + 1'b1) : sent_r;
    byte_nxt = byte_r;
    k_nxt    = k_r;
    idle_nxt = idle_r;
    for (int i = 0; i < LANES; i++)
    begin
      if (slot && f_out_valid && f_out[TXD_LANE+:2] == 2'(i))
      begin
        byte_nxt[i] = f_out[7:0];
        k_nxt[i]    = f_out[TXD_K];
        idle_nxt[i] = f_out[TXD_IDLE];
      end
      else if (slot && ctrl_r[CTRL_PRE])
      begin
        byte_nxt[i] = IDLE_CODE[7:0];
        k_nxt[i]    = IDLE_CODE[8];
        idle_nxt[i] = IDLE_CODE[9];
      end
      else if (slot)
      begin
        byte_nxt[i] = 8'h00;
        k_nxt[i]    = 1'b0;
        idle_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awrdy_r  <= 1'b0;
      wrdy_r   <= 1'b0;
      arrdy_r  <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
      ctrl_r   <= CTRL_RESET;
      sent_r   <= '0;
      cnt_r    <= '0;
      lclk_r   <= 1'b0;
      byte_r   <= '0;
      k_r      <= '0;
      idle_r   <= '0;
    end
    else
    begin
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awrdy_r  <= awrdy_nxt;
      wrdy_r   <= wrdy_nxt;
      arrdy_r  <= arrdy_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      bresp_r  <= bresp_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
      ctrl_r   <= ctrl_nxt;
      sent_r   <= sent_nxt;
      cnt_r    <= cnt_nxt;
      lclk_r   <= lclk_nxt;
      byte_r   <= byte_nxt;
      k_r      <= k_nxt;
      idle_r   <= idle_nxt;
    end
  end

  assign S_AXI_AWREADY         = awrdy_r;
  assign S_AXI_WREADY          = wrdy_r;
  assign S_AXI_BVALID          = bvalid_r;
  assign S_AXI_BRESP           = bresp_r;
  assign S_AXI_ARREADY         = arrdy_r;
  assign S_AXI_RVALID          = rvalid_r;
  assign S_AXI_RDATA           = rdata_r;
  assign S_AXI_RRESP           = rresp_r;
  assign par.tx_byte_in        = byte_r;
  assign par.tx_special_flag   = k_r;
  assign par.tx_idle_req_n     = idle_r;
  assign par.tx_lane_if_clk    = {LANES{lclk_r}};
  assign par.lane_off          = ctrl_r[CTRL_OFF+:LANES];
  assign par.lane_alt_pair_sel = ctrl_r[CTRL_ALT+:LANES];
  assign par.tx_common_clk_sel = ctrl_r[CTRL_COM];
  assign par.tx_both_pairs_on  = ctrl_r[CTRL_BOTH];
  assign par.tx_hf_boost_on    = ctrl_r[CTRL_BOOST];
  assign par.precoded_mode_on  = ctrl_r[CTRL_PRE];
  assign par.half_rate_on      = ctrl_r[CTRL_HALF];
  assign par.double_rate_on    = ctrl_r[CTRL_DDR];
endmodule : stfe_host

// ==== stfe_dev.sv ====
/*
  Transmit end: four lanes, each sampling its parallel inputs at both
  edges of its interface clock (lane A's under common clock select),
  encoding to ten-bit characters unless precoded, and shifting them onto
  a primary and a redundant pair. Assumes the lane clocks are plain levels
  synchronous to CLOCK.
*/
`timescale 1ns/1ps
module stfe_dev (
  input  wire logic                    CLOCK,
  input  wire logic                    RESET,
  stfe_par_if.dev                      par,
  output logic [stfe_pkg::LANES-1:0]   LINK_PRI_P,
  output logic [stfe_pkg::LANES-1:0]   LINK_PRI_N,
  output logic [stfe_pkg::LANES-1:0]   LINK_PRI_OE,
  output logic [stfe_pkg::LANES-1:0]   LINK_RED_P,
  output logic [stfe_pkg::LANES-1:0]   LINK_RED_N,
  output logic [stfe_pkg::LANES-1:0]   LINK_RED_OE,
  output logic [stfe_pkg::LANES-1:0]   LINK_HF_BOOST
);
  import stfe_pkg::*;

  logic [LANES-1:0][CHAR_BITS-1:0] sh_r, sh_nxt;
  logic [LANES-1:0] prev_r, prev_nxt, rd_r, rd_nxt, ph_r, ph_nxt, bit_r, bit_nxt;
  logic [LANES-1:0] pp_r, pp_nxt, pn_r, pn_nxt, poe_r, poe_nxt;
  logic [LANES-1:0] rp_r, rp_nxt, rn_r, rn_nxt, roe_r, roe_nxt, boost_r, boost_nxt;

  // count of ones, shared by both sub-block disparity checks
  function automatic logic [2:0] ones6(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int b = 0; b < 6; b++)
      n = 3'(n + 3'(v[b]));
    return n;
  endfunction : ones6

  // 5b/6b codes, negative disparity column, a first
  function automatic logic [5:0] six_tab(input logic [4:0] x);
    case (x)
      5'd0:    return 6'b100111;
      5'd1:    return 6'b011101;
      5'd2:    return 6'b101101;
      5'd3:    return 6'b110001;
      5'd4:    return 6'b110101;
      5'd5:    return 6'b101001;
      5'd6:    return 6'b011001;
      5'd7:    return 6'b111000;
      5'd8:    return 6'b111001;
      5'd9:    return 6'b100101;
      5'd10:   return 6'b010101;
      5'd11:   return 6'b110100;
      5'd12:   return 6'b001101;
      5'd13:   return 6'b101100;
      5'd14:   return 6'b011100;
      5'd15:   return 6'b010111;
      5'd16:   return 6'b011011;
      5'd17:   return 6'b100011;
      5'd18:   return 6'b010011;
      5'd19:   return 6'b110010;
      5'd20:   return 6'b001011;
      5'd21:   return 6'b101010;
      5'd22:   return 6'b011010;
      5'd23:   return 6'b111010;
      5'd24:   return 6'b110011;
      5'd25:   return 6'b100110;
      5'd26:   return 6'b010110;
      5'd27:   return 6'b110110;
      5'd28:   return 6'b001110;
      5'd29:   return 6'b101110;
      5'd30:   return 6'b011110;
      default: return 6'b101011;
    endcase
  endfunction : six_tab

  // 3b/4b codes, negative disparity column, f first
  function automatic logic [3:0] four_tab(input logic [2:0] y);
    case (y)
      3'd0:    return 4'b1011;
      3'd1:    return 4'b1001;
      3'd2:    return 4'b0101;
      3'd3:    return 4'b1100;
      3'd4:    return 4'b1101;
      3'd5:    return 4'b1010;
      3'd6:    return 4'b0110;
      default: return 4'b1110;
    endcase
  endfunction : four_tab

  // returns {new disparity, abcdei fghj}; rd high means positive
  function automatic logic [10:0] enc(input logic [7:0] d, input logic k,
                                      input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] six;
    logic [3:0] four;
    logic       rd1;
    logic       rd2;
    logic       k28;
    logic       alt;
    x    = d[4:0];
    y    = d[7:5];
    k28  = k && x == K28_X;
    six  = k28 ? K28_SIX : six_tab(x);
    rd1  = rd;
    if (ones6(six) != 3'd3)
    begin
      six = rd ? ~six : six;
      rd1 = ~rd;
    end
    else if (x == 5'd7 && rd)
      six = ~six;
    // alternate .7 avoids a run of five equal bits
    alt  = y == 3'd7 && (k || (!rd1 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
                            || (rd1 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    four = alt ? 4'b0111 : four_tab(y);
    rd2  = rd1;
    if (ones6({2'b00, four}) != 3'd2)
    begin
      four = rd1 ? ~four : four;
      rd2  = ~rd1;
    end
    else if (y == 3'd3)
      four = rd1 ? ~four : four;
    else if (k28 && !rd1)
      four = ~four;
    return {rd2, six, four};
  endfunction : enc

  // per lane: edge detect, sample, encode, serialize, steer pairs
  always_comb
  begin
    logic        seen, ld, pri_on, red_on, b;
    logic [10:0] ch;
    seen   = 1'b0;
    ld     = 1'b0;
    pri_on = 1'b0;
    red_on = 1'b0;
    b      = 1'b0;
    ch     = '0;
    for (int i = 0; i < LANES; i++)
    begin
      seen = par.tx_common_clk_sel ? par.tx_lane_if_clk[0]
                                   : par.tx_lane_if_clk[i];
      ld   = seen != prev_r[i] && !par.lane_off[i];
      prev_nxt[i] = seen;
      if (par.precoded_mode_on)
        ch = {rd_r[i], par.tx_idle_req_n[i], par.tx_special_flag[i],
              par.tx_byte_in[i]};
      else if (!par.tx_idle_req_n[i])
        ch = enc(par.tx_special_flag[i] ? IDLE_ALT : IDLE_BYTE, 1'b1, rd_r[i]);
      else
        ch = enc(par.tx_byte_in[i], par.tx_special_flag[i], rd_r[i]);
      sh_nxt[i] = sh_r[i];
      rd_nxt[i] = rd_r[i];
      ph_nxt[i] = ~ph_r[i];
      if (ld)
      begin
        sh_nxt[i] = ch[CHAR_BITS-1:0];
        rd_nxt[i] = ch[CHAR_BITS];
        ph_nxt[i] = 1'b0;
      end
      // rotate so a late host repeats the character, not zeros
      else if (!par.lane_off[i] && (!par.half_rate_on || ph_r[i]))
        sh_nxt[i] = {sh_r[i][CHAR_BITS-2:0], sh_r[i][CHAR_BITS-1]};
      pri_on = !par.lane_off[i] && (par.tx_both_pairs_on
                                    || !par.lane_alt_pair_sel[i]);
      red_on = !par.lane_off[i] && (par.tx_both_pairs_on
                                    || par.lane_alt_pair_sel[i]);
      b = sh_nxt[i][CHAR_BITS-1];
      bit_nxt[i]   = b;
      pp_nxt[i]    = pri_on & b;
      pn_nxt[i]    = pri_on & ~b;
      poe_nxt[i]   = pri_on;
      rp_nxt[i]    = red_on & b;
      rn_nxt[i]    = red_on & ~b;
      roe_nxt[i]   = red_on;
      // gain on each transition, where the high-frequency content is
      boost_nxt[i] = par.tx_hf_boost_on && (pri_on || red_on)
                     && b != bit_r[i];
    end
  end

  // lane state registers, four copies
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      sh_r    <= '0;
      prev_r  <= '0;
      rd_r    <= {LANES{RD_RESET}};
      ph_r    <= '0;
      bit_r   <= '0;
      pp_r    <= '0;
      pn_r    <= '0;
      poe_r   <= '0;
      rp_r    <= '0;
      rn_r    <= '0;
      roe_r   <= '0;
      boost_r <= '0;
    end
    else
    begin
      sh_r    <= sh_nxt;
      prev_r  <= prev_nxt;
      rd_r    <= rd_nxt;
      ph_r    <= ph_nxt;
      bit_r   <= bit_nxt;
      pp_r    <= pp_nxt;
      pn_r    <= pn_nxt;
      poe_r   <= poe_nxt;
      rp_r    <= rp_nxt;
      rn_r    <= rn_nxt;
      roe_r   <= roe_nxt;
      boost_r <= boost_nxt;
    end
  end

  assign LINK_PRI_P    = pp_r;
  assign LINK_PRI_N    = pn_r;
  assign LINK_PRI_OE   = poe_r;
  assign LINK_RED_P    = rp_r;
  assign LINK_RED_N    = rn_r;
  assign LINK_RED_OE   = roe_r;
  assign LINK_HF_BOOST = boost_r;
endmodule : stfe_dev

// ==== stfe_checks_asserts.sv ====
/*
  Concurrent checks on the parallel link and the serial link pins.
  Assumes one clock for both ends and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module stfe_checks
  import stfe_pkg::*;
(
  input wire logic                             CLOCK,
  input wire logic                             RESET,
  input wire logic [stfe_pkg::LANES-1:0][7:0]  tx_byte_in,
  input wire logic [stfe_pkg::LANES-1:0]       tx_lane_if_clk,
  input wire logic [stfe_pkg::LANES-1:0]       lane_off,
  input wire logic [stfe_pkg::LANES-1:0]       lane_alt_pair_sel,
  input wire logic                             tx_both_pairs_on,
  input wire logic                             tx_hf_boost_on,
  input wire logic                             half_rate_on,
  input wire logic [stfe_pkg::LANES-1:0]       LINK_PRI_P,
  input wire logic [stfe_pkg::LANES-1:0]       LINK_PRI_N,
  input wire logic [stfe_pkg::LANES-1:0]       LINK_PRI_OE,
  input wire logic [stfe_pkg::LANES-1:0]       LINK_RED_P,
  input wire logic [stfe_pkg::LANES-1:0]       LINK_RED_N,
  input wire logic [stfe_pkg::LANES-1:0]       LINK_RED_OE,
  input wire logic [stfe_pkg::LANES-1:0]       LINK_HF_BOOST
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  // lane clock edge at full rate, then ten cycles to the next edge
  sequence lclk_edge;
    $changed(tx_lane_if_clk[0]) && !half_rate_on;
  endsequence
  sequence lclk_hold;
    $stable(tx_lane_if_clk[0])[*8] ##1 $stable(tx_lane_if_clk[0]) ##1 $changed(tx_lane_if_clk[0]);
  endsequence
  pri_enable_a:
    assert property (!$past(RESET) |-> LINK_PRI_OE == $past(~lane_off &
      ({LANES{tx_both_pairs_on}} | ~lane_alt_pair_sel))) else $error("primary enable wrong");
  red_enable_a:
    assert property (!$past(RESET) |-> LINK_RED_OE == $past(~lane_off &
      ({LANES{tx_both_pairs_on}} | lane_alt_pair_sel))) else $error("redundant enable wrong");
  off_quiet_a:
    assert property (!$past(RESET) |-> ((LINK_PRI_P | LINK_PRI_N | LINK_RED_P | LINK_RED_N)
      & $past(lane_off)) == '0) else $error("disabled lane drives");
  pair_compl_a:
    assert property (((LINK_PRI_P ^ LINK_PRI_N) | ~LINK_PRI_OE) == '1)
      else $error("pair not complementary");
  boost_off_a:
    assert property ((!tx_hf_boost_on)[*3] |=> LINK_HF_BOOST == '0) else $error("boost unasked");
  boost_edge_a:
    assert property (tx_hf_boost_on[*3] ##0 (LINK_PRI_OE[0] && $stable(LINK_PRI_OE[0])
      && $changed(LINK_PRI_P[0])) |-> LINK_HF_BOOST[0]) else $error("boost missing");
  clk_common_a:
    assert property (tx_lane_if_clk == {LANES{tx_lane_if_clk[0]}}) else $error("lane clocks differ");
  lclk_rate_a:
    assert property (lclk_edge |=> lclk_hold) else $error("lane clock period wrong");
  data_edge_a:
    assert property ($changed(tx_byte_in) |-> $changed(tx_lane_if_clk[0]))
      else $error("byte moved off clock edge");
endmodule : stfe_checks

// ==== test_serdes_transmit_front_end.sv ====
/*
  Testbench: registers over AXI4-Lite, both ends joined, pins observed.
  Assumes the designer's register map and one 50 MHz clock.
*/
`timescale 1ns/1ps
module test_serdes_transmit_front_end;
  import stfe_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [3:0]       awaddr = 4'h0, araddr = 4'h0;
  logic [31:0]      wdata = 32'h0000_0000, val, rdata;
  logic             awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic             awready, wready, bvalid, arready, rvalid, found;
  logic [1:0]       bresp, rresp, resp;
  logic [LANES-1:0] pri_p, pri_n, pri_oe, red_p, red_n, red_oe, boost;
  int               errors = 0, n_compared = 0, k, n_tx = 0;
  // ctrl value, expected primary and redundant enables
  logic [31:0] row_c [6] = '{32'h0000_0000, 32'h0000_F000, 32'h0000_5004,
                             32'h0000_3304, 32'h0000_0F00, 32'h0000_6000};
  logic [3:0]  row_p [6] = '{4'hF, 4'h0, 4'hF, 4'hC, 4'h0, 4'h9};
  logic [3:0]  row_r [6] = '{4'h0, 4'hF, 4'hF, 4'hC, 4'h0, 4'h6};
  logic [9:0]  codes [2] = '{10'h2A5, 10'h15A};
  always #10 clk = ~clk;
  stfe_par_if stfe_par_if_inst ();
  stfe_host stfe_host_inst (.CLOCK(clk), .RESET(rst), .par(stfe_par_if_inst.host),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  stfe_dev stfe_dev_inst (.CLOCK(clk), .RESET(rst), .par(stfe_par_if_inst.dev),
    .LINK_PRI_P(pri_p), .LINK_PRI_N(pri_n), .LINK_PRI_OE(pri_oe), .LINK_RED_P(red_p),
    .LINK_RED_N(red_n), .LINK_RED_OE(red_oe), .LINK_HF_BOOST(boost));
  stfe_checks stfe_checks_inst (.CLOCK(clk), .RESET(rst),
    .tx_byte_in(stfe_par_if_inst.tx_byte_in), .tx_lane_if_clk(stfe_par_if_inst.tx_lane_if_clk),
    .lane_off(stfe_par_if_inst.lane_off), .lane_alt_pair_sel(stfe_par_if_inst.lane_alt_pair_sel),
    .tx_both_pairs_on(stfe_par_if_inst.tx_both_pairs_on),
    .tx_hf_boost_on(stfe_par_if_inst.tx_hf_boost_on),
    .half_rate_on(stfe_par_if_inst.half_rate_on), .LINK_PRI_P(pri_p), .LINK_PRI_N(pri_n),
    .LINK_PRI_OE(pri_oe), .LINK_RED_P(red_p), .LINK_RED_N(red_n), .LINK_RED_OE(red_oe),
    .LINK_HF_BOOST(boost));
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // write: both channels offered together, bready held until bvalid
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 500 && !bvalid; i++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    resp = bresp;
    check(32'(i == 500), 32'h0000_0000);
    if (i == 500) complete_run();
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 500 && !rvalid; i++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    val = rdata;
    resp = rresp;
    check(32'(i == 500), 32'h0000_0000);
    if (i == 500) complete_run();
  endtask : rd
  // watch a lane's primary bit stream for either of two characters
  task automatic grab(input int ln, input logic [9:0] c1, input logic [9:0] c2);
    logic [9:0] sr;
    sr = 10'h000;
    found = 1'b0;
    repeat (80)
    begin
      @(posedge clk);
      sr = {sr[8:0], pri_p[ln]};
      if (sr === c1 || sr === c2) found = 1'b1;
    end
  endtask : grab
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL);
    check(val, 32'h0000_0000);
    rd(OFS_STATUS);
    check(val, 32'h0000_0100);
    rd(4'h2);
    check(32'(resp), 32'(RESP_SLVERR));
    wr(4'h2, 32'h0000_0000);
    check(32'(resp), 32'(RESP_SLVERR));
    for (k = 0; k < 6; k++)
    begin
      wr(OFS_CTRL, row_c[k]);
      repeat (3) @(posedge clk);
      check(32'(pri_oe), 32'(row_p[k]));
      check(32'(red_oe), 32'(row_r[k]));
      rd(OFS_CTRL);
      check(val, row_c[k]);
    end
    // precoded: code bits 9, 8 and 7..0 go straight to the wire
    wr(OFS_CTRL, 32'h0000_0001);
    for (k = 0; k < 2; k++)
    begin
      fork
        wr(OFS_TXDATA, {22'h0, codes[k]});
        grab(0, codes[k], codes[k]);
      join
      check(32'(found), 32'h0000_0001);
    end
    // encoder on, boost and common clock: data byte, then idle lane
    wr(OFS_CTRL, 32'h0000_000A);
    fork
      wr(OFS_TXDATA, 32'h0000_02B5);
      grab(0, 10'h2AA, 10'h2AA);
    join
    check(32'(found), 32'h0000_0001);
    grab(1, 10'h0FA, 10'h305);
    check(32'(found), 32'h0000_0001);
    // fill the buffer past full: writes stall, then drain it
    for (k = 0; k < 80; k++) wr(OFS_TXDATA, 32'h0000_0E00);
    n_tx = 83;
    rd(OFS_STATUS);
    check(val & 32'h0000_033F, 32'h0000_0220);
    repeat (450) @(posedge clk);
    rd(OFS_STATUS);
    check(val, 32'h0000_0100);
    rd(OFS_SENT);
    check(val & 32'h0000_FFFF, 32'(n_tx));
    complete_run();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule : test_serdes_transmit_front_end
